// >>> common/piw_pkg.sv
package piw_pkg;
  // register offsets on the port
  localparam logic [7:0] ADDR_EXT_EN = 8'h84;
  localparam logic [7:0] ADDR_EXT_FLG = 8'h85;
  localparam logic [7:0] ADDR_TIMER_AND_LEGACY_PIN_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_SH_FLG = 8'h95;
  localparam logic [7:0] ADDR_P1_WAKE = 8'h96;
  localparam logic [7:0] ADDR_IE_MAIN = 8'ha8;
  localparam logic [7:0] ADDR_IE_SEC = 8'ha9;
  localparam logic [7:0] ADDR_LVD_CTL = 8'hbf;
  // field positions
  localparam int TIMER_AND_LEGACY_PIN_CONTROL_IT0 = 0;
  localparam int TIMER_AND_LEGACY_PIN_CONTROL_IE0 = 1;
  localparam int TIMER_AND_LEGACY_PIN_CONTROL_IT1 = 2;
  localparam int TIMER_AND_LEGACY_PIN_CONTROL_IE1 = 3;
  localparam int SHF_P1 = 1;
  localparam int SHF_LV = 7;
  localparam int IEM_EX0 = 0;
  localparam int IEM_EX1 = 2;
  localparam int IEM_EA = 7;
  localparam int IES_P1 = 1;
  localparam int IES_SHARED = 2;
  localparam int LVD_IRQ_EN = 7;
  localparam int LVD_STATUS = 6;
  localparam int LVD_SEL_W = 4;
  // read default byte and ie_main write mask
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] IEM_MASK = 8'hbf;
  // synchroniser lane map: legacy pins, extended pins, port1, comparator
  localparam int SYN_L0 = 0;
  localparam int SYN_L1 = 1;
  localparam int SYN_EXT = 2;
  localparam int SYN_P1 = 10;
  localparam int SYN_LV = 18;
  localparam int SYN_W = 19;
  localparam logic [18:0] SYN_RST = 19'h3ffff;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HALT = 3'b010,
    ST_RESUME = 3'b100
  } piw_mode_type;
  typedef struct packed {
    logic [7:0] ext_en;
    logic [7:0] ext_flg;
    logic [7:0] timer_and_legacy_pin_control;
    logic lv_flag;
    logic p1_flag;
    logic [7:0] p1_wake;
    logic [7:0] ie_main;
    logic [7:0] ie_sec;
    logic lv_irq_en;
    logic [3:0] lvd_sel;
    piw_mode_type mode;
    logic [7:0] rdata;
    logic irq_l0;
    logic irq_l1;
    logic irq_ext;
    logic irq_p1;
    logic irq_lv;
    logic wake_req;
    logic pd_refused;
    logic halt_active;
  } piw_state_type;
endpackage

// >>> common/piw_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface piw_sync_if #(parameter int W = 19);
  logic [W-1:0] level;
  logic [W-1:0] fall;
  logic [W-1:0] change;
  modport drv (output level, output fall, output change);
  modport use_side (input level, input fall, input change);
endinterface // piw_sync_if
`default_nettype wire

// >>> hdl/piw_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module piw_pin_sync #(
  parameter int W = 19,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [W-1:0] pins_async,
  piw_sync_if.drv sy
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] level;
    logic [W-1:0] prev;
  } piw_sync_state_type;
  piw_sync_state_type s_reg;
  piw_sync_state_type s_next;

  // meta feeds only the second stage; edges use the later stages
  always_comb begin
    s_next = s_reg;
    s_next.meta = pins_async;
    s_next.level = s_reg.meta;
    s_next.prev = s_reg.level;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{meta: RST_VAL, level: RST_VAL, prev: RST_VAL};
    end else begin
      s_reg <= s_next;
    end
  end

  assign sy.level = s_reg.level;
  assign sy.fall = s_reg.prev & ~s_reg.level;
  assign sy.change = s_reg.prev ^ s_reg.level;
endmodule // piw_pin_sync
`default_nettype wire

// >>> hdl/piw_top.sv
// Functional notes
// - trigger bit 0 level, 1 falling edge
// - extended pins falling edge only
// - port1 change either direction triggers
// - refuse power down on enabled low pin
// - extended enables gate irq and wake
// - extended also needs shared enable
// - extended flags set regardless of enable
// - extended flags cleared only by software
// - legacy flags set on edge, auto clear
// - legacy enables gate irq and wake
// - global enable blocks all irq entry
// - low voltage flag hardware set only
// - port1 flag set by enabled pin change
// - port1 flag auto or software clear
// - shared flags: write 0 clears
// - port1 wake register per pin enable
// - shared bit gates extended and lowvolt
// - lowvolt irq needs both enables
// - four bit threshold select to comparator
// - port1 irq enable not gating wake
// - resume runs one instruction first
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module piw_top
  import piw_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [7:0] rdata,
  input wire logic legacy_pin_zero,
  input wire logic legacy_pin_one,
  input wire logic [7:0] extended_pins,
  input wire logic [7:0] port1_pins,
  input wire logic low_voltage_status,
  output logic [3:0] lvd_level_sel,
  input wire logic ack_legacy_zero,
  input wire logic ack_legacy_one,
  input wire logic ack_port1,
  input wire logic power_down_request,
  input wire logic instr_done,
  output logic irq_legacy_zero,
  output logic irq_legacy_one,
  output logic irq_extended,
  output logic irq_port1,
  output logic irq_low_voltage,
  output logic wake_request,
  output logic pd_refused,
  output logic halt_active
);
  piw_state_type s_reg;
  piw_state_type s_next;
  piw_sync_if #(.W(SYN_W)) sy ();

  ////////////////////////////////////////////////////////////
  // two-stage pin synchroniser
  piw_pin_sync #(.W(SYN_W), .RST_VAL(SYN_RST)) u_sync (
    .clock(clock),
    .rstn(rstn),
    .pins_async({low_voltage_status, port1_pins, extended_pins,
                 legacy_pin_one, legacy_pin_zero}),
    .sy(sy)
  );

  // set wins over clear
  function automatic logic sticky(input logic old, input logic set,
                                  input logic clr);
    sticky = set | (old & ~clr);
  endfunction

  ////////////////////////////////////////////////////////////
  logic lvl0;
  logic lvl1;
  logic [7:0] lvl_ext;
  logic [7:0] fall_ext;
  logic [7:0] chg_p1;
  logic lv_rise;
  logic ea;
  logic shared;
  logic ex0;
  logic ex1;
  logic req0;
  logic req1;
  logic req_ext;
  logic req_p1;
  logic req_lv;
  logic wake_any;
  logic refuse;
  logic run;

  always_comb begin
    lvl0 = sy.level[SYN_L0];
    lvl1 = sy.level[SYN_L1];
    lvl_ext = sy.level[SYN_EXT +: 8];
    fall_ext = sy.fall[SYN_EXT +: 8];
    chg_p1 = sy.change[SYN_P1 +: 8];
    lv_rise = sy.change[SYN_LV] & sy.level[SYN_LV];
    ea = s_reg.ie_main[IEM_EA];
    shared = s_reg.ie_sec[IES_SHARED];
    ex0 = s_reg.ie_main[IEM_EX0];
    ex1 = s_reg.ie_main[IEM_EX1];
    run = (s_reg.mode == ST_RUN);
    // level or edge per trigger bit
    req0 = ex0 & (s_reg.timer_and_legacy_pin_control[TIMER_AND_LEGACY_PIN_CONTROL_IT0] ? s_reg.timer_and_legacy_pin_control[TIMER_AND_LEGACY_PIN_CONTROL_IE0] : ~lvl0);
    req1 = ex1 & (s_reg.timer_and_legacy_pin_control[TIMER_AND_LEGACY_PIN_CONTROL_IT1] ? s_reg.timer_and_legacy_pin_control[TIMER_AND_LEGACY_PIN_CONTROL_IE1] : ~lvl1);
    req_ext = shared & |(s_reg.ext_en & s_reg.ext_flg);
    // port1 irq enable gates irq only
    req_p1 = s_reg.ie_sec[IES_P1] & s_reg.p1_flag;
    req_lv = shared & s_reg.lv_irq_en & s_reg.lv_flag;
    wake_any = (ex0 & (~lvl0 | s_reg.timer_and_legacy_pin_control[TIMER_AND_LEGACY_PIN_CONTROL_IE0]))
             | (ex1 & (~lvl1 | s_reg.timer_and_legacy_pin_control[TIMER_AND_LEGACY_PIN_CONTROL_IE1]))
             | (shared & |(s_reg.ext_en & (~lvl_ext | s_reg.ext_flg)))
             | |(s_reg.p1_wake & chg_p1);
    refuse = (ex0 & ~lvl0) | (ex1 & ~lvl1)
           | (shared & |(s_reg.ext_en & ~lvl_ext));
  end

  ////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    s_next.rdata = RST_BYTE;
    s_next.wake_req = 1'b0;
    s_next.pd_refused = 1'b0;
    // software writes
    if (wr_strobe) begin
      if (addr == ADDR_EXT_EN) begin
        s_next.ext_en = wdata;
      end else if (addr == ADDR_EXT_FLG) begin
        s_next.ext_flg = wdata;
      end else if (addr == ADDR_TIMER_AND_LEGACY_PIN_CONTROL) begin
        s_next.timer_and_legacy_pin_control = wdata;
      end else if (addr == ADDR_SH_FLG) begin
        s_next.lv_flag = s_reg.lv_flag & wdata[SHF_LV];
        s_next.p1_flag = s_reg.p1_flag & wdata[SHF_P1];
      end else if (addr == ADDR_P1_WAKE) begin
        s_next.p1_wake = wdata;
      end else if (addr == ADDR_IE_MAIN) begin
        s_next.ie_main = wdata & IEM_MASK;
      end else if (addr == ADDR_IE_SEC) begin
        s_next.ie_sec = wdata;
      end else if (addr == ADDR_LVD_CTL) begin
        s_next.lv_irq_en = wdata[LVD_IRQ_EN];
        s_next.lvd_sel = wdata[LVD_SEL_W-1:0];
      end
    end
    // edge sets flag, no auto clear
    s_next.ext_flg = s_next.ext_flg | fall_ext;
    // legacy flags set on edge, cleared on vector
    s_next.timer_and_legacy_pin_control[TIMER_AND_LEGACY_PIN_CONTROL_IE0] = sticky(s_next.timer_and_legacy_pin_control[TIMER_AND_LEGACY_PIN_CONTROL_IE0],
                                   sy.fall[SYN_L0], ack_legacy_zero);
    s_next.timer_and_legacy_pin_control[TIMER_AND_LEGACY_PIN_CONTROL_IE1] = sticky(s_next.timer_and_legacy_pin_control[TIMER_AND_LEGACY_PIN_CONTROL_IE1],
                                   sy.fall[SYN_L1], ack_legacy_one);
    s_next.p1_flag = sticky(s_next.p1_flag, |(chg_p1 & s_reg.p1_wake),
                            ack_port1);
    s_next.lv_flag = sticky(s_next.lv_flag, lv_rise, 1'b0);
    // power mode sequencing
    case (s_reg.mode)
      ST_RUN: begin
        if (power_down_request) begin
          if (refuse) begin
            s_next.pd_refused = 1'b1;
          end else begin
            s_next.mode = ST_HALT;
          end
        end
      end
      ST_HALT: begin
        if (wake_any) begin
          s_next.mode = ST_RESUME;
          s_next.wake_req = 1'b1;
        end
      end
      ST_RESUME: begin
        if (instr_done) begin
          s_next.mode = ST_RUN;
        end
      end
      default: begin
        s_next.mode = ST_RUN;
      end
    endcase
    s_next.halt_active = (s_next.mode == ST_HALT);
    s_next.irq_l0 = run & ea & req0;
    s_next.irq_l1 = run & ea & req1;
    s_next.irq_ext = run & ea & req_ext;
    s_next.irq_p1 = run & ea & req_p1;
    s_next.irq_lv = run & ea & req_lv;
    // read port
    if (rd_strobe) begin
      if (addr == ADDR_EXT_EN) begin
        s_next.rdata = s_reg.ext_en;
      end else if (addr == ADDR_EXT_FLG) begin
        s_next.rdata = s_reg.ext_flg;
      end else if (addr == ADDR_TIMER_AND_LEGACY_PIN_CONTROL) begin
        s_next.rdata = s_reg.timer_and_legacy_pin_control;
      end else if (addr == ADDR_SH_FLG) begin
        s_next.rdata[SHF_LV] = s_reg.lv_flag;
        s_next.rdata[SHF_P1] = s_reg.p1_flag;
      end else if (addr == ADDR_P1_WAKE) begin
        s_next.rdata = s_reg.p1_wake;
      end else if (addr == ADDR_IE_MAIN) begin
        s_next.rdata = s_reg.ie_main;
      end else if (addr == ADDR_IE_SEC) begin
        s_next.rdata = s_reg.ie_sec;
      end else if (addr == ADDR_LVD_CTL) begin
        s_next.rdata[LVD_IRQ_EN] = s_reg.lv_irq_en;
        s_next.rdata[LVD_STATUS] = sy.level[SYN_LV];
        s_next.rdata[LVD_SEL_W-1:0] = s_reg.lvd_sel;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{mode: ST_RUN, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////
  assign rdata = s_reg.rdata;
  assign lvd_level_sel = s_reg.lvd_sel;
  assign irq_legacy_zero = s_reg.irq_l0;
  assign irq_legacy_one = s_reg.irq_l1;
  assign irq_extended = s_reg.irq_ext;
  assign irq_port1 = s_reg.irq_p1;
  assign irq_low_voltage = s_reg.irq_lv;
  assign wake_request = s_reg.wake_req;
  assign pd_refused = s_reg.pd_refused;
  assign halt_active = s_reg.halt_active;

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  logic [4:0] irq_vec;
  assign irq_vec = {irq_legacy_zero, irq_legacy_one, irq_extended,
                    irq_port1, irq_low_voltage};

  sequence s_halt_wake;
    s_reg.mode == ST_HALT && wake_any;
  endsequence

  sequence s_resumed;
    wake_request && s_reg.mode == ST_RESUME;
  endsequence

  a_level_trigger: assert property (
    run && ea && ex0 && !s_reg.timer_and_legacy_pin_control[TIMER_AND_LEGACY_PIN_CONTROL_IT0] && !lvl0
    |=> irq_legacy_zero)
    else $error("level request on pin zero not raised");

  a_ext_edge_flag: assert property (
    fall_ext != 8'h00 |=> (s_reg.ext_flg & $past(fall_ext)) == $past(fall_ext))
    else $error("extended edge flag not set");

  a_port1_change: assert property (
    |(chg_p1 & s_reg.p1_wake) |=> s_reg.p1_flag)
    else $error("port1 change flag not set");

  a_pd_refuse: assert property (
    run && power_down_request && refuse
    |=> pd_refused && s_reg.mode == ST_RUN && !halt_active)
    else $error("power down taken with enabled pin low");

  a_wake_path: assert property (
    s_halt_wake |=> s_resumed)
    else $error("wake not raised from halt");

  a_ea_block: assert property (
    !ea |=> irq_vec == 5'h00)
    else $error("interrupt raised with global enable off");

  a_resume_hold: assert property (
    s_reg.mode == ST_RESUME && !instr_done |=> irq_vec == 5'h00 [*2])
    else $error("interrupt raised before first instruction");

  a_flag_clear: assert property (
    wr_strobe && addr == ADDR_SH_FLG && !wdata[SHF_LV] && !lv_rise
    |=> !s_reg.lv_flag)
    else $error("low voltage flag not cleared by zero write");

  a_lv_gate: assert property (
    irq_low_voltage |-> $past(s_reg.lv_irq_en) && $past(shared))
    else $error("low voltage irq without both enables");

  a_legacy_ack: assert property (
    ack_legacy_zero && !sy.fall[SYN_L0] |=> !s_reg.timer_and_legacy_pin_control[TIMER_AND_LEGACY_PIN_CONTROL_IE0])
    else $error("pin zero flag not cleared on vector");

  a_edge_trigger: assert property (
    run && ea && ex0 && s_reg.timer_and_legacy_pin_control[TIMER_AND_LEGACY_PIN_CONTROL_IT0] && s_reg.timer_and_legacy_pin_control[TIMER_AND_LEGACY_PIN_CONTROL_IE0]
    |=> irq_legacy_zero)
    else $error("edge request on pin zero not raised");

  a_ext_gate: assert property (
    irq_extended |-> $past(shared) && $past(ea))
    else $error("extended irq without shared enable");

  a_ext_refuse: assert property (
    run && power_down_request && shared && (s_reg.ext_en & ~lvl_ext) != 8'h00
    |=> pd_refused && !halt_active)
    else $error("power down taken with extended pin low");

  a_ext_sticky: assert property (
    !(wr_strobe && addr == ADDR_EXT_FLG)
    |=> (s_reg.ext_flg & $past(s_reg.ext_flg)) == $past(s_reg.ext_flg))
    else $error("extended flag cleared without software write");

  a_p1_gate: assert property (
    irq_port1 |-> $past(s_reg.ie_sec[IES_P1]))
    else $error("port1 irq without its enable");

  a_p1_ack: assert property (
    ack_port1 && (chg_p1 & s_reg.p1_wake) == 8'h00 |=> !s_reg.p1_flag)
    else $error("port1 flag not cleared on vector");

  a_lv_hw_set: assert property (
    !s_reg.lv_flag && !lv_rise |=> !s_reg.lv_flag)
    else $error("low voltage flag set without comparator rise");

  a_halt_entry: assert property (
    run && power_down_request && !refuse |=> halt_active)
    else $error("power down not taken with pins idle");

  a_wake_pulse: assert property (
    wake_request |=> !wake_request && !halt_active)
    else $error("wake pulse longer than one cycle");
endmodule // piw_top
`default_nettype wire

// >>> tb/piw_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module piw_pin_model (
  input wire logic clock,
  output logic [1:0] legacy,
  output logic [7:0] ext,
  output logic [7:0] port1,
  output logic lv
);
  // pins rest at their pull-up level, supply starts good
  initial begin
    legacy = 2'h3;
    ext = 8'hff;
    port1 = 8'hff;
    lv = 1'b0;
  end
  // levels change right after an edge and stay until the next call
  task automatic drive(input logic [1:0] l, input logic [7:0] e, input logic [7:0] p,
                       input logic v);
    @(posedge clock);
    legacy <= l;
    ext <= e;
    port1 <= p;
    lv <= v;
  endtask
endmodule // piw_pin_model
`default_nettype wire

// >>> tb/pin_and_lowvolt_interrupt_wake_test.sv
`timescale 1ns/1ps
`default_nettype none
module pin_and_lowvolt_interrupt_wake_test;
  import piw_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  logic [4:0] ctl_v = 5'h00;
  logic [7:0] rdata, p1, ext;
  logic [3:0] lvd_level_sel;
  logic [1:0] leg;
  logic lv, irq_l0, irq_l1, irq_ext, irq_p1, irq_lv, wake_request, pd_refused, halt_active;
  int num_errors = 0;
  int compares = 0;
  int seed = 32'h47a985a8;
  int mdl[int];
  logic [7:0] regs[8] = '{ADDR_EXT_EN, ADDR_EXT_FLG, ADDR_TIMER_AND_LEGACY_PIN_CONTROL, ADDR_SH_FLG, ADDR_P1_WAKE,
                          ADDR_IE_MAIN, ADDR_IE_SEC, ADDR_LVD_CTL};
  always #2 clock = ~clock;
  piw_pin_model pm (.clock(clock), .legacy(leg), .ext(ext), .port1(p1), .lv(lv));
  piw_top dut (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rdata(rdata), .legacy_pin_zero(leg[0]), .legacy_pin_one(leg[1]),
    .extended_pins(ext), .port1_pins(p1), .low_voltage_status(lv),
    .lvd_level_sel(lvd_level_sel), .ack_legacy_zero(ctl_v[0]), .ack_legacy_one(ctl_v[1]),
    .ack_port1(ctl_v[2]), .power_down_request(ctl_v[3]), .instr_done(ctl_v[4]),
    .irq_legacy_zero(irq_l0), .irq_legacy_one(irq_l1), .irq_extended(irq_ext),
    .irq_port1(irq_p1), .irq_low_voltage(irq_lv), .wake_request(wake_request),
    .pd_refused(pd_refused), .halt_active(halt_active));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic chb(input string n, input logic s, input logic e);
    chk(n, {7'h00, s}, {7'h00, e});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // model follows each write: flags clear on 0, masks hide reserved bits
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_strobe <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_strobe <= 1'b0;
    // registered requests follow the new register value one edge later
    @(posedge clock);
    #1;
    if (a == ADDR_SH_FLG) mdl[a] = mdl[a] & d;
    else if (a == ADDR_IE_MAIN) mdl[a] = d & IEM_MASK;
    else if (a == ADDR_LVD_CTL) mdl[a] = (mdl[a] & 8'h40) | (d & 8'h8f);
    else if (mdl.exists(a)) mdl[a] = d;
  endtask
  task automatic rc(input logic [7:0] a);
    @(posedge clock);
    rd_strobe <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_strobe <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), rdata, mdl.exists(a) ? 8'(mdl[a]) : 8'h00);
  endtask
  task automatic pins(input logic [1:0] l, input logic [7:0] e, input logic [7:0] p,
                      input logic v);
    pm.drive(l, e, p, v);
    step(5);
  endtask
  task automatic ctl(input logic [4:0] v);
    @(posedge clock);
    ctl_v <= v;
    @(posedge clock);
    ctl_v <= 5'h00;
    #1;
  endtask
  task automatic wake(input logic [1:0] l, input logic [7:0] p);
    int n;
    n = 0;
    ctl(5'h08);
    chb("halt", halt_active, 1'b1);
    pm.drive(l, 8'hff, p, 1'b0);
    while (wake_request !== 1'b1 && n < 12) begin
      @(posedge clock);
      #1;
      n++;
    end
    chb("wake", wake_request, 1'b1);
    chb("halt", halt_active, 1'b0);
    ctl(5'h10);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end
  initial begin
    logic [1:0] lo;
    foreach (regs[i]) mdl[regs[i]] = 0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    step(3);
    foreach (regs[i]) rc(regs[i]);
    rc(8'h80);
    for (int k = 0; k < 3; k++) begin
      foreach (regs[i]) begin
        wr(regs[i], 8'($random(seed)));
        rc(regs[i]);
      end
      chk("sel", {4'h0, lvd_level_sel}, 8'(mdl[ADDR_LVD_CTL]) & 8'h0f);
    end
    wr(8'h80, 8'hff);
    rc(8'h80);
    foreach (regs[i]) wr(regs[i], 8'h00);
    pins(2'h3, 8'hfe, 8'hff, 1'b0);
    mdl[ADDR_EXT_FLG] = 1;
    rc(ADDR_EXT_FLG);
    wr(ADDR_EXT_FLG, 8'h00);
    step(4);
    rc(ADDR_EXT_FLG);
    wr(ADDR_EXT_EN, 8'h01);
    wr(ADDR_IE_MAIN, 8'h80);
    pins(2'h3, 8'hff, 8'hff, 1'b0);
    pins(2'h3, 8'hfe, 8'hff, 1'b0);
    mdl[ADDR_EXT_FLG] = 1;
    chb("irq_ext", irq_ext, 1'b0);
    wr(ADDR_IE_SEC, 8'h04);
    chb("irq_ext", irq_ext, 1'b1);
    ctl(5'h07);
    rc(ADDR_EXT_FLG);
    wr(ADDR_IE_MAIN, 8'h00);
    chb("irq_ext", irq_ext, 1'b0);
    wr(ADDR_EXT_FLG, 8'h00);
    pins(2'h3, 8'hff, 8'hff, 1'b0);
    for (int i = 0; i < 2; i++) begin
      lo = ~(2'b01 << i);
      wr(ADDR_IE_MAIN, i ? 8'h84 : 8'h81);
      wr(ADDR_TIMER_AND_LEGACY_PIN_CONTROL, i ? 8'h04 : 8'h01);
      pins(lo, 8'hff, 8'hff, 1'b0);
      mdl[ADDR_TIMER_AND_LEGACY_PIN_CONTROL] = i ? 8'h0c : 8'h03;
      rc(ADDR_TIMER_AND_LEGACY_PIN_CONTROL);
      pins(2'h3, 8'hff, 8'hff, 1'b0);
      chb("irq_leg", i ? irq_l1 : irq_l0, 1'b1);
      ctl(5'h01 << i);
      mdl[ADDR_TIMER_AND_LEGACY_PIN_CONTROL] = i ? 8'h04 : 8'h01;
      rc(ADDR_TIMER_AND_LEGACY_PIN_CONTROL);
      chb("irq_leg", i ? irq_l1 : irq_l0, 1'b0);
      wr(ADDR_TIMER_AND_LEGACY_PIN_CONTROL, 8'h00);
      pins(lo, 8'hff, 8'hff, 1'b0);
      ctl(5'h01 << i);
      chb("irq_leg", i ? irq_l1 : irq_l0, 1'b1);
      pins(2'h3, 8'hff, 8'hff, 1'b0);
      chb("irq_leg", i ? irq_l1 : irq_l0, 1'b0);
      wr(ADDR_TIMER_AND_LEGACY_PIN_CONTROL, 8'h00);
    end
    wr(ADDR_IE_MAIN, 8'h00);
    wr(ADDR_P1_WAKE, 8'h10);
    pins(2'h3, 8'hff, 8'hfe, 1'b0);
    rc(ADDR_SH_FLG);
    pins(2'h3, 8'hff, 8'hee, 1'b0);
    mdl[ADDR_SH_FLG] = 8'h02;
    rc(ADDR_SH_FLG);
    wr(ADDR_SH_FLG, 8'hfd);
    rc(ADDR_SH_FLG);
    pins(2'h3, 8'hff, 8'hfe, 1'b0);
    mdl[ADDR_SH_FLG] = 8'h02;
    wr(ADDR_SH_FLG, 8'hff);
    rc(ADDR_SH_FLG);
    wr(ADDR_IE_MAIN, 8'h80);
    wr(ADDR_IE_SEC, 8'h02);
    chb("irq_p1", irq_p1, 1'b1);
    ctl(5'h04);
    mdl[ADDR_SH_FLG] = 0;
    rc(ADDR_SH_FLG);
    pins(2'h3, 8'hff, 8'hfe, 1'b1);
    mdl[ADDR_SH_FLG] = 8'h80;
    mdl[ADDR_LVD_CTL] = 8'h40;
    rc(ADDR_SH_FLG);
    rc(ADDR_LVD_CTL);
    wr(ADDR_LVD_CTL, 8'h80);
    chb("irq_lv", irq_lv, 1'b0);
    wr(ADDR_IE_SEC, 8'h06);
    chb("irq_lv", irq_lv, 1'b1);
    wr(ADDR_SH_FLG, 8'h7f);
    rc(ADDR_SH_FLG);
    chb("irq_lv", irq_lv, 1'b0);
    wr(ADDR_IE_SEC, 8'h00);
    wr(ADDR_IE_MAIN, 8'h01);
    wr(ADDR_TIMER_AND_LEGACY_PIN_CONTROL, 8'h01);
    pins(2'h2, 8'hff, 8'hfe, 1'b0);
    ctl(5'h08);
    chb("refused", pd_refused, 1'b1);
    chb("halt", halt_active, 1'b0);
    pins(2'h3, 8'hff, 8'hfe, 1'b0);
    wr(ADDR_TIMER_AND_LEGACY_PIN_CONTROL, 8'h01);
    wake(2'h2, 8'hfe);
    chb("irq_leg", irq_l0, 1'b0);
    pins(2'h3, 8'hff, 8'hfe, 1'b0);
    wr(ADDR_TIMER_AND_LEGACY_PIN_CONTROL, 8'h01);
    wake(2'h3, 8'hee);
    complete_run();
  end
endmodule // pin_and_lowvolt_interrupt_wake_test
`default_nettype wire
